// ---- src/sfw_flash_protect_id.sv ----
// Serial flash write-enable, status-protect and identification decoder
`timescale 1ns/1ns

module sfw_flash_protect_id #(
  parameter logic [7:0] OP_WRITE_ENABLE = sfw_pkg::OP_WRITE_ENABLE_DEF,
  parameter logic [7:0] OP_STATUS_ARM = sfw_pkg::OP_STATUS_ARM_DEF,
  parameter logic [7:0] OP_STATUS_WRITE = sfw_pkg::OP_STATUS_WRITE_DEF,
  parameter logic [7:0] MFR_CODE = sfw_pkg::MFR_CODE_DEF,
  parameter logic [7:0] DEV_CODE = sfw_pkg::DEV_CODE_DEF
) (
  // System clock and reset
  input wire logic sysClk,
  input wire logic rst,
  // Serial link pins
  input wire logic serialClk,
  input wire logic chipSelN,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEnN,
  // Write-protect pin
  input wire logic writeProtectN,
  // Program engine events, system clock domain
  input wire logic autoIncEnter,
  input wire logic autoIncTopReached,
  // Protection state
  output sfw_pkg::sfw_status_t status,
  output logic statusWriteArmed
);

  import sfw_pkg::*;

  // Link domain, cleared while the frame is idle
  logic linkClr;
  logic [COUNT_W-1:0] bitCount;
  logic [COUNT_W-1:0] next_bitCount;
  logic [7:0] shiftReg;
  logic [7:0] next_shiftReg;
  logic [7:0] frameOp;
  logic [7:0] next_frameOp;
  logic idAddrLsb;
  logic next_idAddrLsb;
  logic [OUTBIT_W-1:0] outBit;
  logic [OUTBIT_W-1:0] next_outBit;
  logic [7:0] shiftIn;
  logic idCmd;

  // Link domain words that survive the frame end
  sfw_frame_t hand;
  sfw_frame_t next_hand;

  // Link domain output stage
  logic next_serialOut;
  logic next_serialOutEnN;
  logic [7:0] idByte;

  // Chip select is the frame's own reset, so no edge is needed after it
  assign linkClr = chipSelN | rst;
  assign shiftIn = {shiftReg[6:0], serialIn};
  assign idCmd = (frameOp == OP_ID_READ_A) || (frameOp == OP_ID_READ_B);

  always_comb begin
    next_shiftReg = shiftIn;
    next_bitCount = bitCount;
    next_frameOp = frameOp;
    next_idAddrLsb = idAddrLsb;
    next_outBit = outBit;
    if (bitCount != COUNT_W'(ADDR_END)) begin
      next_bitCount = bitCount + COUNT_W'(1);
    end
    if (bitCount == COUNT_W'(CMD_BITS - 1)) begin
      next_frameOp = shiftIn;
    end
    // Last address bit picks the first code shown
    if (bitCount == COUNT_W'(ADDR_END - 1)) begin
      next_idAddrLsb = serialIn;
    end
    // Free wrap keeps the two codes alternating
    if (idCmd && bitCount == COUNT_W'(ADDR_END)) begin
      next_outBit = outBit + OUTBIT_W'(1);
    end
  end

  always_ff @(posedge serialClk or posedge linkClr) begin
    if (linkClr) begin
      bitCount <= '0;
      shiftReg <= '0;
      frameOp <= '0;
      idAddrLsb <= 1'b0;
      outBit <= '0;
    end else begin
      bitCount <= next_bitCount;
      shiftReg <= next_shiftReg;
      frameOp <= next_frameOp;
      idAddrLsb <= next_idAddrLsb;
      outBit <= next_outBit;
    end
  end

  // Toggles mark a fresh word; the words stand still once select is high
  always_comb begin
    next_hand = hand;
    if (bitCount == COUNT_W'(CMD_BITS - 1)) begin
      next_hand.opcode = shiftIn;
      next_hand.opSeq = ~hand.opSeq;
    end
    if (bitCount == COUNT_W'(DATA_END - 1)) begin
      next_hand.data = shiftIn;
      next_hand.dataSeq = ~hand.dataSeq;
    end
  end

  always_ff @(posedge serialClk or posedge rst) begin
    if (rst) begin
      hand <= '0;
    end else begin
      hand <= next_hand;
    end
  end

  // Address bit zero xor byte parity selects the code
  always_comb begin
    idByte = MFR_CODE;
    if (idAddrLsb ^ outBit[OUTBIT_W-1]) begin
      idByte = DEV_CODE;
    end
  end

  // Data leaves on the falling edge; driver released when select rises
  always_comb begin
    next_serialOut = 1'b0;
    next_serialOutEnN = 1'b1;
    if (idCmd && bitCount == COUNT_W'(ADDR_END)) begin
      next_serialOutEnN = 1'b0;
      next_serialOut = idByte[3'd7 - outBit[2:0]];
    end
  end

  always_ff @(negedge serialClk or posedge linkClr) begin
    if (linkClr) begin
      serialOut <= 1'b0;
      serialOutEnN <= 1'b1;
    end else begin
      serialOut <= next_serialOut;
      serialOutEnN <= next_serialOutEnN;
    end
  end

  // System domain: pin synchronisers
  logic [1:0] pinSync;
  logic csSync;
  logic wpSync;

  sfw_pin_sync #(
    .WIDTH(2),
    .RESET_VAL(PIN_SYNC_RESET)
  ) u_pin_sync (
    .clk(sysClk),
    .rst(rst),
    .async({chipSelN, writeProtectN}),
    .synced(pinSync)
  );

  assign csSync = pinSync[1];
  assign wpSync = pinSync[0];

  // System domain: frame end detection and execution state
  logic csPrev;
  logic next_csPrev;
  logic opSeen;
  logic next_opSeen;
  logic dataSeen;
  logic next_dataSeen;
  logic frameEnd;
  logic newOp;
  logic newData;
  logic writeAllowed;
  sfw_status_t next_status;
  logic next_statusWriteArmed;

  // Link words are read only after select has been high two cycles
  assign frameEnd = csSync & ~csPrev;
  assign newOp = hand.opSeq != opSeen;
  assign newData = hand.dataSeq != dataSeen;
  // Lock-down applies only with the protect pin low
  assign writeAllowed = wpSync | ~status.protectLockBit;

  always_comb begin
    next_csPrev = csSync;
    next_opSeen = opSeen;
    next_dataSeen = dataSeen;
    next_status = status;
    next_statusWriteArmed = statusWriteArmed;
    // Engine events first, so a command in the same cycle wins
    if (autoIncEnter && status.writeEnableLatch) begin
      next_status.autoIncrementProgramFlag = 1'b1;
    end
    if (autoIncTopReached) begin
      next_status.autoIncrementProgramFlag = 1'b0;
      next_status.writeEnableLatch = 1'b0;
    end
    if (frameEnd) begin
      next_opSeen = hand.opSeq;
      next_dataSeen = hand.dataSeq;
    end
    // A short frame leaves everything, arming included
    if (frameEnd && newOp) begin
      // Any complete instruction other than arming wastes the arming
      next_statusWriteArmed = 1'b0;
      unique case (hand.opcode)
        OP_WRITE_ENABLE: begin
          next_status.writeEnableLatch = 1'b1;
        end
        OP_WRITE_DISABLE: begin
          next_status.writeEnableLatch = 1'b0;
          next_status.autoIncrementProgramFlag = 1'b0;
        end
        OP_STATUS_ARM: begin
          next_statusWriteArmed = 1'b1;
        end
        OP_STATUS_WRITE: begin
          // Needs arming, a whole data byte and permission
          if (statusWriteArmed && newData && writeAllowed) begin
            next_status.blockProtectBit0 = hand.data[STAT_BP0_POS];
            next_status.blockProtectBit1 = hand.data[STAT_BP1_POS];
            next_status.protectLockBit = hand.data[STAT_BPL_POS];
          end
        end
        default: begin
          next_status = next_status;
        end
      endcase
    end
  end

  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      csPrev <= 1'b1;
      opSeen <= 1'b0;
      dataSeen <= 1'b0;
      status <= STATUS_RESET;
      statusWriteArmed <= 1'b0;
    end else begin
      csPrev <= next_csPrev;
      opSeen <= next_opSeen;
      dataSeen <= next_dataSeen;
      status <= next_status;
      statusWriteArmed <= next_statusWriteArmed;
    end
  end

endmodule

// ---- shared/sfw_pkg.sv ----
// Shared constants and carrier types for the flash protect and ID decoder
package sfw_pkg;

  // Serial framing, counted in link clock rising edges
  localparam int unsigned CMD_BITS = 8;
  localparam int unsigned DATA_END = 16;
  localparam int unsigned ADDR_END = 32;
  localparam int unsigned COUNT_W = 6;
  localparam int unsigned OUTBIT_W = 4;

  // Fixed opcodes
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_ID_READ_A = 8'h90;
  localparam logic [7:0] OP_ID_READ_B = 8'hab;

  // Default opcodes for the remaining commands
  localparam logic [7:0] OP_WRITE_ENABLE_DEF = 8'h06;
  localparam logic [7:0] OP_STATUS_ARM_DEF = 8'h50;
  localparam logic [7:0] OP_STATUS_WRITE_DEF = 8'h01;

  // Positions of the writable bits in the status data byte
  localparam int unsigned STAT_BP0_POS = 2;
  localparam int unsigned STAT_BP1_POS = 3;
  localparam int unsigned STAT_BPL_POS = 7;

  // Identification codes; values are arbitrary
  localparam logic [7:0] MFR_CODE_DEF = 8'h5a;
  localparam logic [7:0] DEV_CODE_DEF = 8'h3c;

  // Reset values
  localparam logic [1:0] PIN_SYNC_RESET = 2'b11;

  // Words handed from the link domain to the system domain
  typedef struct packed {
    logic [7:0] opcode;
    logic opSeq;
    logic [7:0] data;
    logic dataSeq;
  } sfw_frame_t;

  // Control and protection state
  typedef struct packed {
    logic writeEnableLatch;
    logic autoIncrementProgramFlag;
    logic blockProtectBit1;
    logic blockProtectBit0;
    logic protectLockBit;
  } sfw_status_t;

  localparam sfw_status_t STATUS_RESET = '{default: 1'b0};

endpackage

// ---- src/sfw_pin_sync.sv ----
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ns
module sfw_pin_sync #(
  parameter int unsigned WIDTH = 2,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Levels
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= RESET_VAL;
      synced <= RESET_VAL;
    end else begin
      meta <= async;
      synced <= meta;
    end
  end

endmodule

// ---- testbench/sfw_chk.sv ----
// Assertion checker for the flash protect and ID decoder
`timescale 1ns/1ns
module sfw_chk (
  // Clocks and reset
  input wire logic sysClk,
  input wire logic rst,
  // Link pins
  input wire logic chipSelN,
  input wire logic serialOut,
  input wire logic serialOutEnN,
  // Control and state
  input wire logic writeProtectN,
  input wire logic autoIncTopReached,
  input wire sfw_pkg::sfw_status_t status,
  input wire logic statusWriteArmed
);
  import sfw_pkg::*;
  logic [3:0] sinceRise;
  logic [3:0] next_sinceRise;
  logic [2:0] prot;
  assign prot = {status.blockProtectBit1, status.blockProtectBit0,
    status.protectLockBit};
  // Cycles since select went high, saturating
  always_comb begin
    next_sinceRise = sinceRise;
    if (!chipSelN) begin
      next_sinceRise = 4'h0;
    end else if (sinceRise != 4'hf) begin
      next_sinceRise = sinceRise + 4'h1;
    end
  end
  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      sinceRise <= 4'hf;
    end else begin
      sinceRise <= next_sinceRise;
    end
  end
  default clocking cb @(posedge sysClk); endclocking
  default disable iff (rst);
  a_latch_set_end: assert property ($rose(status.writeEnableLatch)
    |-> sinceRise inside {[4'h2:4'h5]}) else $error("latch set off end");
  a_prot_at_end: assert property ($changed(prot)
    |-> sinceRise inside {[4'h2:4'h5]}) else $error("protect off end");
  a_write_arm: assert property ($changed(prot)
    |-> $past(statusWriteArmed, 2)) else $error("write without arming");
  a_locked_hold: assert property (!writeProtectN &&
    !$past(writeProtectN, 8) && $past(status.protectLockBit)
    |-> $stable(prot[2:1])) else $error("locked bits changed");
  a_lock_no_clear: assert property ($fell(status.protectLockBit)
    |-> $past(writeProtectN, 5)) else $error("lock cleared while pinned");
  a_write_disable_cmd_both: assert property ($fell(status.autoIncrementProgramFlag)
    |-> !status.writeEnableLatch) else $error("flag cleared alone");
  a_top_clears: assert property (autoIncTopReached &&
    sinceRise == 4'hf |=> status[4:3] == 2'b00) else $error("top kept");
  a_out_idle: assert property (chipSelN
    |-> serialOutEnN && !serialOut) else $error("output while idle");
  c_latch: cover property ($rose(status.writeEnableLatch));
  c_lock: cover property ($rose(status.protectLockBit));
  c_id: cover property (!serialOutEnN);
endmodule

bind sfw_flash_protect_id sfw_chk sfw_chk_i (.sysClk(sysClk), .rst(rst),
  .chipSelN(chipSelN), .serialOut(serialOut),
  .serialOutEnN(serialOutEnN), .writeProtectN(writeProtectN),
  .autoIncTopReached(autoIncTopReached), .status(status),
  .statusWriteArmed(statusWriteArmed));

// ---- testbench/sfw_host_model.sv ----
// Link host model framing commands on the serial pins
`timescale 1ns/1ns
module sfw_host_model (
  // Serial link pins
  output logic serialClk,
  output logic chipSelN,
  output logic serialIn,
  input wire logic serialOut
);
  initial begin
    serialClk = 1'b0;
    chipSelN = 1'b1;
    serialIn = 1'b0;
  end
  // Clock stands low between frames; offsets clear sysClk edges for a transfer started on one, but back-to-back transfers can hit them
  task automatic xfer(input logic [47:0] b, input int n,
    output logic [15:0] rx);
    rx = 16'h0;
    #11 chipSelN = 1'b0;
    for (int i = 0; i < n; i++) begin
      serialIn = b[47-i];
      #7 serialClk = 1'b1;
      rx = {rx[14:0], serialOut};
      #8 serialClk = 1'b0;
    end
    #3 chipSelN = 1'b1;
    serialIn = ~serialIn;
    #140;
  endtask
endmodule

// ---- testbench/test_sfw_flash_protect_id.sv ----
// Self-checking bench for the flash protect and ID decoder
`timescale 1ns/1ns
module test_sfw_flash_protect_id;
  import sfw_pkg::*;
  logic sysClk = 1'b0;
  logic rst = 1'b1;
  logic writeProtectN = 1'b1;
  logic autoIncEnter = 1'b0;
  logic autoIncTopReached = 1'b0;
  logic serialClk, chipSelN, serialIn, serialOut, serialOutEnN;
  logic statusWriteArmed;
  sfw_status_t status;
  logic [15:0] rx;
  int miscompares = 0;
  int compares = 0;
  sfw_flash_protect_id sfw_flash_protect_id_i (.sysClk(sysClk), .rst(rst),
    .serialClk(serialClk), .chipSelN(chipSelN), .serialIn(serialIn),
    .serialOut(serialOut), .serialOutEnN(serialOutEnN),
    .writeProtectN(writeProtectN), .autoIncEnter(autoIncEnter),
    .autoIncTopReached(autoIncTopReached), .status(status),
    .statusWriteArmed(statusWriteArmed));
  sfw_host_model sfw_host_model_i (.serialClk(serialClk),
    .chipSelN(chipSelN), .serialIn(serialIn), .serialOut(serialOut));
  always #10 sysClk = ~sysClk;
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic st(input logic [4:0] exp);
    cmp({11'h0, status}, {11'h0, exp});
  endtask
  task automatic op(input logic [7:0] o, input logic [7:0] d, input int n);
    sfw_host_model_i.xfer({o, d, 32'h0}, n, rx);
  endtask
  task automatic sw(input logic [7:0] d);
    op(OP_STATUS_ARM_DEF, 8'h0, 8);
    op(OP_STATUS_WRITE_DEF, d, 16);
  endtask
  task automatic pulse(input logic top);
    repeat (12) @(posedge sysClk);
    autoIncEnter <= !top;
    autoIncTopReached <= top;
    @(posedge sysClk);
    autoIncEnter <= 1'b0;
    autoIncTopReached <= 1'b0;
    repeat (2) @(posedge sysClk);
  endtask
  task automatic wp(input logic v);
    @(posedge sysClk);
    writeProtectN <= v;
    repeat (8) @(posedge sysClk);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Hang guard, far above the expected run
  initial begin
    repeat (5000) @(posedge sysClk);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge sysClk);
    rst <= 1'b0;
    repeat (3) @(posedge sysClk);
    op(OP_WRITE_ENABLE_DEF, 8'h0, 8);
    st(5'h10);
    op(OP_WRITE_DISABLE, 8'h0, 7);
    st(5'h10);
    pulse(1'b0);
    st(5'h18);
    op(OP_WRITE_DISABLE, 8'h0, 8);
    st(5'h00);
    op(OP_WRITE_ENABLE_DEF, 8'h0, 8);
    pulse(1'b0);
    pulse(1'b1);
    st(5'h00);
    $display("test latch done");
    op(OP_STATUS_WRITE_DEF, 8'hff, 16);
    st(5'h00);
    op(OP_STATUS_ARM_DEF, 8'h0, 8);
    cmp({15'h0, statusWriteArmed}, 16'h1);
    op(OP_WRITE_ENABLE_DEF, 8'h0, 8);
    cmp({15'h0, statusWriteArmed}, 16'h0);
    op(OP_STATUS_WRITE_DEF, 8'hff, 16);
    st(5'h10);
    sw(8'hff);
    st(5'h17);
    wp(1'b0);
    sw(8'h00);
    st(5'h17);
    wp(1'b1);
    sw(8'h00);
    st(5'h10);
    wp(1'b0);
    sw(8'h84);
    st(5'h13);
    wp(1'b1);
    $display("test status done");
    for (int k = 0; k < 4; k++) begin
      sfw_host_model_i.xfer({k[1] ? OP_ID_READ_B : OP_ID_READ_A, 23'h0,
        k[0], 16'h0}, 48, rx);
      cmp(rx, k[0] ? {DEV_CODE_DEF, MFR_CODE_DEF} :
        {MFR_CODE_DEF, DEV_CODE_DEF});
      cmp({15'h0, serialOutEnN}, 16'h1);
    end
    $display("test id done");
    tally_and_finish();
  end
endmodule
